// ==== rtl/can_msg_cfg.svh ====
`ifndef CAN_MSG_CFG_SVH
`define CAN_MSG_CFG_SVH
// ********************************************
// register offsets
// ********************************************
`define OFS_RR1 8'h04
`define OFS_RR2 8'h05
`define OFS_RIM1 8'h06
`define OFS_RIM2 8'h07
`define OFS_TRS1 8'h08
`define OFS_TRS2 8'h09
`define OFS_INT_MASK 8'h0A
`define OFS_MOD 8'h10
`define OFS_INT 8'h11
`define OFS_CTRL 8'h12
`define OFS_TX_CHECK_COUNT 8'h15
`define OFS_DESC_BASE 8'h40
`define OFS_DESC_TOP 8'h5F
`define OFS_DATA_BASE 8'h80
// ********************************************
// field positions
// ********************************************
`define MOD_BS_BIT 2
`define MOD_RES_BIT 1
`define INT_RX_BIT 0
`define INT_TX_CHECK_BIT 1
`define CTRL_MM_BIT 0
`define CTRL_TCE_BIT 1
`define DLC_MAX 4'h8
// ********************************************
// reset values and counts
// ********************************************
`define TX_CHECK_RESET 8'h00
`define TX_CHECK_LIMIT 8'h04
`define TX_CHECK_STEP 8'h01
`define MSG_COUNT 16
`endif

// ==== rtl/can_msg_pkg.sv ====
package can_msg_pkg;
    typedef struct packed {
        logic [10:0] id;
        logic rtr;
        logic [3:0] dlc;
    } desc_type;

    typedef struct packed {
        logic valid;
        logic ext_id;
        logic rtr;
        logic [10:0] id;
        logic [3:0] dlc;
        logic [63:0] data;
    } rx_frame_type;

    typedef struct packed {
        logic valid;
        logic [3:0] slot;
        logic [63:0] data;
    } tx_check_type;

    typedef enum logic [2:0] {
        TX_IDLE = 3'b001,
        TX_BUSY = 3'b010,
        TX_FAIL = 3'b100
    } tx_state_type;
endpackage : can_msg_pkg

// ==== rtl/can_message_memory_tx_check.sv ====
`include "can_msg_cfg.svh"
module can_message_memory_tx_check
    import can_msg_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic host_port_select,
    input wire logic serial_timing_select,
    input wire rx_frame_type rx_frame,
    input wire tx_check_type tx_readback,
    input wire logic tx_done,
    input wire logic tx_disturbed,
    output logic tx_start,
    output logic [3:0] tx_slot,
    output logic [63:0] tx_data,
    output desc_type tx_desc,
    output logic error_frame,
    output logic bus_off,
    output logic irq_n,
    output logic serial_mode,
    output logic serial_timing_b
);
    // ********************************************
    // storage
    // ********************************************
    desc_type desc_reg [0:15];
    logic [63:0] ram_reg [0:15];
    logic [63:0] shadow_reg;
    logic [3:0] last_rd_msg_reg;
    logic last_rd_valid_reg;
    logic [15:0] rx_ready_reg;
    logic [15:0] rx_irq_en_reg;
    logic [15:0] tx_req_reg;
    logic [15:0] rrp_reg;
    logic [7:0] imask_reg;
    logic [7:0] int_reg;
    logic [7:0] ctrl_reg;
    logic [7:0] mode_reg;
    logic [7:0] tx_check_error_count;
    logic bus_off_reg;
    logic [7:0] rdata_reg;
    tx_state_type tx_state_reg;
    tx_state_type tx_state_next;
    logic [3:0] tx_slot_reg;
    logic tx_start_reg;
    logic error_frame_reg;
    logic irq_n_reg;
    logic serial_mode_reg;
    logic serial_timing_reg;
    logic [2:0] port_sel_sync_reg;
    logic [2:0] timing_sel_sync_reg;
    logic [63:0] tx_data_reg;
    desc_type tx_desc_reg;

    // ********************************************
    // address decode
    // ********************************************
    wire sel_data = addr[7];
    wire [3:0] data_msg = addr[6:3];
    wire [2:0] data_byte = addr[2:0];
    wire sel_desc = (addr >= `OFS_DESC_BASE) && (addr <= `OFS_DESC_TOP);
    wire [3:0] desc_idx = addr[4:1];
    wire desc_hi = addr[0];
    wire wr_data = wr && sel_data;
    wire wr_desc = wr && sel_desc;
    wire wr_tx_check_count = wr && (addr == `OFS_TX_CHECK_COUNT);
    wire wr_rr1 = wr && (addr == `OFS_RR1);
    wire wr_rr2 = wr && (addr == `OFS_RR2);
    wire wr_rim1 = wr && (addr == `OFS_RIM1);
    wire wr_rim2 = wr && (addr == `OFS_RIM2);
    wire wr_imask = wr && (addr == `OFS_INT_MASK);
    wire wr_ctrl = wr && (addr == `OFS_CTRL);
    wire wr_int = wr && (addr == `OFS_INT);
    wire wr_mod = wr && (addr == `OFS_MOD);
    wire rd_data = rd && sel_data;
    wire reload_shadow = rd_data && (!last_rd_valid_reg || last_rd_msg_reg != data_msg
        || data_byte == 3'h7);
    wire [63:0] shadow_view = reload_shadow ? ram_reg[data_msg] : shadow_reg;
    wire [7:0] shadow_byte = shadow_view[data_byte*8 +: 8];
    wire monitor_on = ctrl_reg[`CTRL_MM_BIT];
    wire soft_reset = mode_reg[`MOD_RES_BIT];

    // ********************************************
    // acceptance filter
    // ********************************************
    logic [15:0] hit;
    genvar g;
    generate
        for (g = 0; g < `MSG_COUNT; g++) begin : g_cam
            assign hit[g] = (desc_reg[g].id == rx_frame.id);
        end
    endgenerate
    logic [3:0] hit_idx;
    logic hit_any;
    always_comb begin
        hit_idx = 4'h0;
        hit_any = 1'b0;
        for (int i = `MSG_COUNT - 1; i >= 0; i--) begin
            if (hit[i] && !(monitor_on && i == `MSG_COUNT - 1)) begin
                hit_idx = 4'(i);
                hit_any = 1'b1;
            end
        end
    end
    // extended frames never reach the store; monitor slot is entry 15
    wire rx_std = rx_frame.valid && !rx_frame.ext_id && !bus_off_reg;
    wire rx_store_match = rx_std && hit_any && !rx_frame.rtr;
    wire rx_store_mon = rx_std && !hit_any && monitor_on && !rx_frame.rtr;
    wire rx_store = rx_store_match || rx_store_mon;
    wire [3:0] rx_slot = rx_store_match ? hit_idx : 4'hF;
    wire rx_remote = rx_std && hit_any && rx_frame.rtr && desc_reg[hit_idx].rtr;

    // ********************************************
    // transmit check
    // ********************************************
    wire tc_mismatch = ctrl_reg[`CTRL_TCE_BIT] && tx_readback.valid
        && (tx_readback.data != ram_reg[tx_readback.slot]);
    wire [7:0] tx_check_inc = tx_check_error_count + `TX_CHECK_STEP;
    wire tx_check_hit = tc_mismatch && (tx_check_inc == `TX_CHECK_LIMIT);
    logic [3:0] next_req;
    logic any_req;
    always_comb begin
        next_req = 4'h0;
        any_req = 1'b0;
        for (int i = `MSG_COUNT - 1; i >= 0; i--) begin
            if (tx_req_reg[i]) begin
                next_req = 4'(i);
                any_req = 1'b1;
            end
        end
    end

    // ********************************************
    // transmit sequencer
    // ********************************************
    wire [3:0] tx_slot_pick = (tx_state_reg == TX_IDLE) ? next_req : tx_slot_reg;
    always_comb begin
        tx_state_next = tx_state_reg;
        unique case (tx_state_reg)
            TX_IDLE: begin
                if (any_req && !bus_off_reg) begin
                    tx_state_next = TX_BUSY;
                end
            end
            TX_BUSY: begin
                if (tc_mismatch || tx_disturbed) begin
                    tx_state_next = TX_FAIL;
                end else if (tx_done) begin
                    tx_state_next = TX_IDLE;
                end
            end
            TX_FAIL: begin
                tx_state_next = TX_IDLE;
            end
        endcase
    end

    // ********************************************
    // registers
    // ********************************************
    always_ff @(posedge clk) begin
        if (!rst_n || soft_reset) begin
            tx_state_reg <= TX_IDLE;
            tx_slot_reg <= 4'h0;
            tx_start_reg <= 1'b0;
            error_frame_reg <= 1'b0;
        end else begin
            tx_state_reg <= tx_state_next;
            tx_start_reg <= (tx_state_reg == TX_IDLE) && (tx_state_next == TX_BUSY);
            error_frame_reg <= (tx_state_reg == TX_BUSY) && tc_mismatch;
            if (tx_state_reg == TX_IDLE) begin
                tx_slot_reg <= next_req;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            port_sel_sync_reg <= 3'h0;
            timing_sel_sync_reg <= 3'h0;
            serial_mode_reg <= 1'b0;
            serial_timing_reg <= 1'b0;
        end else begin
            port_sel_sync_reg <= {port_sel_sync_reg[1:0], host_port_select};
            timing_sel_sync_reg <= {timing_sel_sync_reg[1:0], serial_timing_select};
            if (port_sel_sync_reg[2] == port_sel_sync_reg[1]) begin
                serial_mode_reg <= port_sel_sync_reg[2];
            end
            if (timing_sel_sync_reg[2] == timing_sel_sync_reg[1]) begin
                serial_timing_reg <= timing_sel_sync_reg[2];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < `MSG_COUNT; i++) begin
                desc_reg[i] <= '0;
                ram_reg[i] <= 64'h0;
            end
        end else begin
            if (wr_desc && !desc_hi) begin
                desc_reg[desc_idx].id[10:3] <= wdata;
            end else if (wr_desc) begin
                desc_reg[desc_idx].id[2:0] <= wdata[7:5];
                desc_reg[desc_idx].rtr <= wdata[4];
                desc_reg[desc_idx].dlc <= (wdata[3:0] > `DLC_MAX) ? `DLC_MAX : wdata[3:0];
            end
            if (rx_store) begin
                ram_reg[rx_slot] <= rx_frame.data;
            end
            if (wr_data && data_byte == 3'h0) begin
                ram_reg[data_msg] <= {shadow_reg[63:8], wdata};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            shadow_reg <= 64'h0;
            last_rd_msg_reg <= 4'h0;
            last_rd_valid_reg <= 1'b0;
            rdata_reg <= 8'h00;
        end else begin
            if (wr_data) begin
                shadow_reg[data_byte*8 +: 8] <= wdata;
                last_rd_valid_reg <= 1'b0;
            end else if (rd_data) begin
                shadow_reg <= shadow_view;
                last_rd_msg_reg <= data_msg;
                last_rd_valid_reg <= 1'b1;
            end
            if (rd) begin
                if (sel_data) begin
                    rdata_reg <= shadow_byte;
                end else if (sel_desc) begin
                    rdata_reg <= desc_hi ? {desc_reg[desc_idx].id[2:0], desc_reg[desc_idx].rtr,
                        desc_reg[desc_idx].dlc} : desc_reg[desc_idx].id[10:3];
                end else begin
                    unique case (addr)
                        `OFS_RR1: rdata_reg <= rx_ready_reg[7:0];
                        `OFS_RR2: rdata_reg <= rx_ready_reg[15:8];
                        `OFS_RIM1: rdata_reg <= rx_irq_en_reg[7:0];
                        `OFS_RIM2: rdata_reg <= rx_irq_en_reg[15:8];
                        `OFS_TRS1: rdata_reg <= tx_req_reg[7:0];
                        `OFS_TRS2: rdata_reg <= tx_req_reg[15:8];
                        `OFS_INT_MASK: rdata_reg <= imask_reg;
                        `OFS_MOD: rdata_reg <= {mode_reg[7:3], bus_off_reg, mode_reg[1:0]};
                        `OFS_INT: rdata_reg <= int_reg;
                        `OFS_CTRL: rdata_reg <= ctrl_reg;
                        `OFS_TX_CHECK_COUNT: rdata_reg <= tx_check_error_count;
                        default: rdata_reg <= 8'h00;
                    endcase
                end
            end
        end
    end

    // ********************************************
    // flags, counters, control
    // ********************************************
    wire [15:0] done_bit = 16'h0001 << tx_slot_reg;
    wire rx_irq_hit = rx_store && rx_irq_en_reg[rx_slot];
    wire [7:0] trs_lo = (wr && addr == `OFS_TRS1) ? wdata : 8'h00;
    wire [7:0] trs_hi = (wr && addr == `OFS_TRS2) ? wdata : 8'h00;
    wire tx_ok = (tx_state_reg == TX_BUSY) && tx_done && !tc_mismatch && !tx_disturbed;
    wire [15:0] done_clr = tx_ok ? done_bit : 16'h0000;
    wire [15:0] remote_bit = rx_remote ? (16'h0001 << hit_idx) : 16'h0000;
    // one write sets several jobs at once; a new job beats a completion
    wire [15:0] tx_req_next = (tx_req_reg & ~done_clr) | {trs_hi, trs_lo} | remote_bit;
    wire irq_int = |(int_reg & imask_reg);
    wire irq_tc = tx_check_hit && imask_reg[`INT_TX_CHECK_BIT];

    always_ff @(posedge clk) begin
        if (!rst_n || soft_reset) begin
            rx_ready_reg <= 16'h0000;
            rx_irq_en_reg <= 16'h0000;
            tx_req_reg <= 16'h0000;
            rrp_reg <= 16'h0000;
            imask_reg <= 8'h00;
            int_reg <= 8'h00;
            ctrl_reg <= 8'h00;
            tx_check_error_count <= `TX_CHECK_RESET;
            bus_off_reg <= 1'b0;
            irq_n_reg <= 1'b1;
        end else begin
            // software clears ready bits by writing zero; a store wins
            if (wr_rr1) rx_ready_reg[7:0] <= rx_ready_reg[7:0] & wdata;
            if (wr_rr2) rx_ready_reg[15:8] <= rx_ready_reg[15:8] & wdata;
            if (rx_store) rx_ready_reg[rx_slot] <= 1'b1;
            if (wr_rim1) rx_irq_en_reg[7:0] <= wdata;
            if (wr_rim2) rx_irq_en_reg[15:8] <= wdata;
            tx_req_reg <= tx_req_next;
            if (rx_remote) rrp_reg[hit_idx] <= 1'b1;
            if (wr_imask) imask_reg <= wdata;
            if (wr_ctrl) ctrl_reg <= wdata;
            if (wr_int) int_reg <= int_reg & wdata;
            if (rx_irq_hit) int_reg[`INT_RX_BIT] <= 1'b1;
            if (tx_check_hit) int_reg[`INT_TX_CHECK_BIT] <= 1'b1;
            if (tc_mismatch) begin
                tx_check_error_count <= tx_check_inc;
            end else if (wr_tx_check_count) begin
                tx_check_error_count <= wdata;
            end
            if (tx_check_hit) begin
                bus_off_reg <= 1'b1;
            end
            irq_n_reg <= !(irq_int || rx_irq_hit || irq_tc);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mode_reg <= 8'h00;
        end else if (wr_mod) begin
            mode_reg <= wdata;
        end
    end

    // ********************************************
    // transmit outputs
    // ********************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tx_data_reg <= 64'h0;
            tx_desc_reg <= '0;
        end else begin
            tx_data_reg <= ram_reg[tx_slot_pick];
            tx_desc_reg <= desc_reg[tx_slot_pick];
        end
    end

    // ********************************************
    // outputs
    // ********************************************
    assign rdata = rdata_reg;
    assign tx_start = tx_start_reg;
    assign tx_slot = tx_slot_reg;
    assign tx_data = tx_data_reg;
    assign tx_desc = tx_desc_reg;
    assign error_frame = error_frame_reg;
    assign bus_off = bus_off_reg;
    assign irq_n = irq_n_reg;
    assign serial_mode = serial_mode_reg;
    assign serial_timing_b = serial_timing_reg;
endmodule : can_message_memory_tx_check

// ==== tb/can_mm_sva.sv ====
module can_mm_sva
    import can_msg_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic host_port_select,
    input wire tx_check_type tx_readback,
    input wire logic tx_start,
    input wire logic [63:0] tx_data,
    input wire logic error_frame,
    input wire logic bus_off,
    input wire logic serial_mode
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************
    // enable snoop
    // ****************
    logic tce_reg;
    always_ff @(posedge clk) begin
        if (!rst_n)
            tce_reg <= 1'b0;
        else if (wr && addr == 8'h12)
            tce_reg <= wdata[1];
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ****************
    // properties
    // ****************
    sequence s_bad;
        tx_readback.valid && tx_readback.data != tx_data && tce_reg && !bus_off;
    endsequence
    sequence s_good;
        tx_readback.valid && tx_readback.data == tx_data;
    endsequence
    property p_bad_ef; s_bad |=> error_frame; endproperty
    property p_good_ef; s_good |=> !error_frame; endproperty
    property p_ef_cause; error_frame |-> $past(tx_readback.valid && tce_reg); endproperty
    property p_ef_pulse; error_frame |=> !error_frame; endproperty
    property p_bo_rise; $rose(bus_off) |-> error_frame; endproperty
    property p_bo_quiet; bus_off |-> !tx_start; endproperty
    property p_unmapped; rd && addr == 8'h20 |=> rdata == 8'h00; endproperty
    property p_rd_hold; !rd |=> $stable(rdata); endproperty
    property p_sel; host_port_select [*8] |-> serial_mode; endproperty
    a_bad_ef: assert property (p_bad_ef) else $error("no error frame on mismatch");
    a_good_ef: assert property (p_good_ef) else $error("error frame on match");
    a_ef_cause: assert property (p_ef_cause) else $error("error frame without readback");
    a_ef_pulse: assert property (p_ef_pulse) else $error("error frame too long");
    a_bo_rise: assert property (p_bo_rise) else $error("bus off without mismatch");
    a_bo_quiet: assert property (p_bo_quiet) else $error("send while bus off");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    a_sel: assert property (p_sel) else $error("serial port not selected");
endmodule : can_mm_sva

bind can_message_memory_tx_check can_mm_sva u_sva (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .host_port_select(host_port_select), .tx_readback(tx_readback),
    .tx_start(tx_start), .tx_data(tx_data), .error_frame(error_frame), .bus_off(bus_off),
    .serial_mode(serial_mode));

// ==== tb/can_bus_partner.sv ====
module can_bus_partner
    import can_msg_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic corrupt,
    input wire logic tx_start,
    input wire logic [3:0] tx_slot,
    input wire logic [63:0] tx_data,
    output tx_check_type tx_readback,
    output logic tx_done,
    output logic tx_disturbed
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************
    // bus echo
    // ****************
    logic [2:0] cnt_reg;
    always_ff @(posedge clk) begin
        tx_done <= 1'b0;
        tx_disturbed <= 1'b0;
        tx_readback.valid <= 1'b0;
        tx_readback.data <= ~tx_readback.data;
        if (!rst_n) begin
            cnt_reg <= 3'h0;
            tx_readback <= '0;
        end else if (tx_start) begin
            cnt_reg <= 3'h5;
        end else if (cnt_reg != 3'h0) begin
            cnt_reg <= cnt_reg - 3'h1;
        end
        if (rst_n && cnt_reg == 3'h2) begin
            tx_readback <= '{1'b1, tx_slot, tx_data ^ {63'h0, corrupt}};
        end
        if (rst_n && cnt_reg == 3'h1) begin
            tx_done <= !corrupt;
            tx_disturbed <= corrupt;
        end
    end
endmodule : can_bus_partner

// ==== tb/can_message_memory_tx_check_tb.sv ====
module can_message_memory_tx_check_tb
    import can_msg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, wr, rd, hps, sts, tx_done, tx_dist, tx_start, error_frame, bus_off, irq_n, smode, stb, corrupt;
    logic [7:0] addr, wdata, rdata, d;
    logic [3:0] tx_slot, first_slot;
    logic [63:0] tx_data;
    rx_frame_type rx_frame;
    tx_check_type tx_rb;
    desc_type tx_desc;
    desc_type first_desc;
    int err_count, n_checks, cyc, ef_cnt, ts_cnt;

    can_message_memory_tx_check dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .host_port_select(hps), .serial_timing_select(sts), .rx_frame(rx_frame),
        .tx_readback(tx_rb), .tx_done(tx_done), .tx_disturbed(tx_dist), .tx_start(tx_start), .tx_slot(tx_slot),
        .tx_data(tx_data), .tx_desc(tx_desc), .error_frame(error_frame), .bus_off(bus_off), .irq_n(irq_n),
        .serial_mode(smode), .serial_timing_b(stb));
    can_bus_partner u_bus (.clk(clk), .rst_n(rst_n), .corrupt(corrupt), .tx_start(tx_start),
        .tx_slot(tx_slot), .tx_data(tx_data), .tx_readback(tx_rb), .tx_done(tx_done), .tx_disturbed(tx_dist));

    always #4 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (error_frame === 1'b1) ef_cnt <= ef_cnt + 1;
        if (tx_start === 1'b1 && ts_cnt == 0) begin
            first_slot <= tx_slot;
            first_desc <= tx_desc;
        end
        if (tx_start === 1'b1) ts_cnt <= ts_cnt + 1;
        if (cyc == 20000) begin
            err_count++;
            summarize();
        end
    end
    // ****************
    // helpers
    // ****************
    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s exp %0h seen %0h", name, exp, seen);
        end
    endtask : check
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
        check(name, d, exp);
    endtask : rd_chk
    task automatic send(input logic ext, input logic rtr, input logic [10:0] id, input logic [63:0] v);
        @(posedge clk);
        rx_frame <= '{1'b1, ext, rtr, id, 4'h8, v};
        @(posedge clk);
        rx_frame.valid <= 1'b0;
    endtask : send
    task automatic wait_ts(input int n);
        for (int i = 0; i < 300 && ts_cnt < n; i++) @(posedge clk);
        repeat (10) @(posedge clk);
        check("starts", ts_cnt, n);
    endtask : wait_ts
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : summarize
    // ****************
    // scenarios
    // ****************
    task automatic t_rx();
        wr_reg(8'h46, 8'h24);
        wr_reg(8'h47, 8'h68);
        rd_chk("desc", 8'h47, 8'h68);
        wr_reg(8'h06, 8'h08);
        wr_reg(8'h0A, 8'h01);
        for (int n = 7; n >= 0; n--) wr_reg(8'h98 + 8'(n), 8'hA0 + 8'(n));
        rd_chk("commit", 8'h98, 8'hA0);
        send(1'b0, 1'b0, 11'h123, 64'hB7B6B5B4B3B2B1B0);
        rd_chk("ready", 8'h04, 8'h08);
        check("irq rx", irq_n, 1'b0);
        rd_chk("no reload", 8'h9B, 8'hA3);
        rd_chk("top reload", 8'h9F, 8'hB7);
        rd_chk("reloaded", 8'h9B, 8'hB3);
        send(1'b0, 1'b0, 11'h555, 64'hC7);
        send(1'b1, 1'b0, 11'h123, 64'hD7);
        rd_chk("kept", 8'h9F, 8'hB7);
        wr_reg(8'h11, 8'h00);
        wr_reg(8'h0A, 8'h00);
        rd_chk("int clr", 8'h11, 8'h00);
        check("irq off", irq_n, 1'b1);
        wr_reg(8'h12, 8'h01);
        send(1'b0, 1'b0, 11'h555, 64'hE7);
        rd_chk("monitor", 8'hF8, 8'hE7);
    endtask : t_rx
    task automatic t_tx();
        wr_reg(8'h12, 8'h00);
        ts_cnt = 0;
        send(1'b0, 1'b1, 11'h123, 64'h0);
        wait_ts(0);
        wr_reg(8'h47, 8'h78);
        send(1'b0, 1'b1, 11'h123, 64'h0);
        wait_ts(1);
        check("tx desc", first_desc, 16'h2478);
        wr_reg(8'h12, 8'h02);
        ts_cnt = 0;
        wr_reg(8'h08, 8'h09);
        wait_ts(2);
        check("first", first_slot, 4'h0);
        check("no error", ef_cnt, 0);
        wr_reg(8'h0A, 8'h02);
        corrupt <= 1'b1;
        wr_reg(8'h08, 8'h08);
        for (int i = 0; i < 500 && bus_off !== 1'b1; i++) @(posedge clk);
        repeat (3) @(posedge clk);
        corrupt <= 1'b0;
        check("errors", ef_cnt, 4);
        rd_chk("count", 8'h15, 8'h04);
        rd_chk("int", 8'h11, 8'h02);
        check("irq", irq_n, 1'b0);
        rd_chk("mode", 8'h10, 8'h04);
        wr_reg(8'h15, 8'h02);
        rd_chk("count wr", 8'h15, 8'h02);
    endtask : t_tx
    task automatic t_pins();
        hps <= 1'b1;
        sts <= 1'b1;
        repeat (12) @(posedge clk);
        check("serial", smode, 1'b1);
        check("timing", stb, 1'b1);
        hps <= 1'b0;
        sts <= 1'b0;
        repeat (12) @(posedge clk);
        check("parallel", smode, 1'b0);
    endtask : t_pins
    task automatic t_reset();
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk("count rst", 8'h15, 8'h00);
        rd_chk("unmapped", 8'h20, 8'h00);
        check("bus on", bus_off, 1'b0);
        check("irq rst", irq_n, 1'b1);
    endtask : t_reset

    initial begin
        clk = 1'b0;
        {wr, rd, hps, sts, corrupt, addr, wdata} = '0;
        rx_frame = '0;
        t_reset();
        t_pins();
        t_rx();
        t_tx();
        t_reset();
        summarize();
    end
endmodule : can_message_memory_tx_check_tb
